/* File: rtl/bcr_common_regs.sv */
`include "bcr_map.svh"

module bcr_common_regs (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Write and read port
  input  wire logic       wr_en,
  input  wire logic [2:0] idx,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  // Core side
  input  wire logic [6:0] flag_set,
  input  wire logic [7:0] status_in,
  output logic      [7:0] int_en_q,
  output logic      [7:0] int_flag_q,
  output logic      [7:0] ctl_two_q,
  output logic      [7:0] ctl_one_q
);

  logic [7:0] int_flag_d;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      int_en_q <= `BCR_RST_INT_EN;
    else if (wr_en && idx == `BCR_IDX_INT_EN)
      int_en_q <= wdata;
  end

  // Hardware set wins over a write in the same cycle
  always_comb
  begin
    int_flag_d = int_flag_q;
    if (wr_en && idx == `BCR_IDX_INT_FLAG)
      int_flag_d = wdata;
    int_flag_d = (int_flag_d | {1'b0, flag_set}) & `BCR_RMASK_INT_FLAG;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      int_flag_q <= `BCR_RST_INT_FLAG;
    else
      int_flag_q <= int_flag_d;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctl_two_q <= `BCR_RST_CTL_TWO;
    else if (wr_en && idx == `BCR_IDX_CTL_TWO)
      ctl_two_q <= wdata & `BCR_WMASK_CTL_TWO;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctl_one_q <= `BCR_RST_CTL_ONE;
    else if (wr_en && idx == `BCR_IDX_CTL_ONE)
      ctl_one_q <= wdata;
  end

  always_comb
  begin
    unique case (idx)
      `BCR_IDX_INT_EN:   rdata = int_en_q;
      `BCR_IDX_INT_FLAG: rdata = int_flag_q;
      `BCR_IDX_STATUS:   rdata = status_in & `BCR_RMASK_STATUS;
      `BCR_IDX_CTL_TWO:  rdata = ctl_two_q;
      `BCR_IDX_CTL_ONE:  rdata = ctl_one_q;
      default:           rdata = 8'h00;
    endcase
  end

endmodule // bcr_common_regs

/* File: rtl/bcr_decode.sv */
// Notes on behaviour
// - All storage is static; three spaces: control registers, packet buffer, PHY registers.
// - Host reads and writes control registers directly over the serial command path.
// - Packet buffer holds transmit and receive areas; host programs their boundaries.
// - Packet buffer reached only by buffer read and write commands, never by address.
// - PHY registers have no serial address; reached only through the MII path.
// - Four banks; bank select field in main control one picks the bank.
// - Each bank holds 32 byte locations chosen by a 5-bit address.
// - Addresses 1Bh to 1Fh reach the same five key registers in every bank.
// - Unimplemented addresses drop writes silently and read as zero.
`include "bcr_map.svh"

module bcr_decode (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Command from the serial engine
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  input  wire logic       cmd_buffer,
  input  wire logic [4:0] cmd_addr,
  input  wire logic [7:0] cmd_wdata,
  output logic            cmd_ready_q,
  // Answer to the serial engine
  output logic            ans_valid_q,
  output logic      [7:0] ans_data_q,
  // Banked registers in the controller core
  output logic            core_rd_q,
  output logic            core_wr_q,
  output logic      [1:0] core_bank_q,
  output logic      [4:0] core_addr_q,
  output logic      [7:0] core_wdata_q,
  input  wire logic [7:0] core_rdata,
  // Packet buffer port
  output logic            buf_rd_q,
  output logic            buf_wr_q,
  output logic      [7:0] buf_wdata_q,
  input  wire logic [7:0] buf_rdata,
  // Key registers toward the core
  input  wire logic [6:0] flag_set,
  input  wire logic [7:0] status_in,
  output logic      [7:0] int_en_q,
  output logic      [7:0] int_flag_q,
  output logic      [7:0] ctl_two_q,
  output logic      [7:0] ctl_one_q
);

  bcr_pkg::bcr_state_type state_q;
  bcr_pkg::bcr_kind_type  kind_q;
  bcr_pkg::bcr_kind_type  kind_d;
  logic                   write_q;
  logic [2:0]             cidx_q;
  logic [7:0]             common_rdata;
  logic [1:0]             bank;
  logic                   take;
  logic                   common_wr;

  // Implemented location below the common region
  function automatic logic is_impl(input logic [1:0] b, input logic [4:0] a);
    logic [31:0] m;
    unique case (b)
      2'h0: m = `BCR_IMPL_BANK0;
      2'h1: m = `BCR_IMPL_BANK1;
      2'h2: m = `BCR_IMPL_BANK2;
      2'h3: m = `BCR_IMPL_BANK3;
    endcase
    return m[a];
  endfunction

  assign bank      = ctl_one_q[`BCR_BANK_MSB:`BCR_BANK_LSB];
  assign take      = cmd_valid && cmd_ready_q;
  assign common_wr = state_q == bcr_pkg::BCR_ST_ACCESS && write_q && kind_q == bcr_pkg::BCR_KIND_COMMON;

  // buffer contents only through buffer commands
  // no address reaches the PHY space
  always_comb
  begin
    if (cmd_buffer)
      kind_d = bcr_pkg::BCR_KIND_BUFFER;
    else if (cmd_addr >= `BCR_COMMON_BASE)
      kind_d = bcr_pkg::BCR_KIND_COMMON;
    else if (is_impl(bank, cmd_addr))
      kind_d = bcr_pkg::BCR_KIND_CORE;
    else
      kind_d = bcr_pkg::BCR_KIND_NONE;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= bcr_pkg::BCR_ST_IDLE;
    else
    begin
      unique case (state_q)
        bcr_pkg::BCR_ST_IDLE:   if (take) state_q <= bcr_pkg::BCR_ST_ACCESS;
        bcr_pkg::BCR_ST_ACCESS: state_q <= bcr_pkg::BCR_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cmd_ready_q <= 1'b1;
    else
      cmd_ready_q <= !take;
  end

  // Command capture
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      kind_q       <= bcr_pkg::BCR_KIND_NONE;
      write_q      <= 1'b0;
      cidx_q       <= 3'h0;
      core_addr_q  <= 5'h00;
      core_wdata_q <= 8'h00;
      buf_wdata_q  <= 8'h00;
    end
    else if (take)
    begin
      kind_q       <= kind_d;
      write_q      <= cmd_write;
      cidx_q       <= 3'(cmd_addr - `BCR_COMMON_BASE);
      core_addr_q  <= cmd_addr;
      core_wdata_q <= cmd_wdata;
      buf_wdata_q  <= cmd_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      core_bank_q <= 2'h0;
    else if (take)
      core_bank_q <= bank;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      core_rd_q <= 1'b0;
      core_wr_q <= 1'b0;
      buf_rd_q  <= 1'b0;
      buf_wr_q  <= 1'b0;
    end
    else
    begin
      core_rd_q <= take && kind_d == bcr_pkg::BCR_KIND_CORE && !cmd_write;
      core_wr_q <= take && kind_d == bcr_pkg::BCR_KIND_CORE && cmd_write;
      buf_rd_q  <= take && kind_d == bcr_pkg::BCR_KIND_BUFFER && !cmd_write;
      buf_wr_q  <= take && kind_d == bcr_pkg::BCR_KIND_BUFFER && cmd_write;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ans_valid_q <= 1'b0;
      ans_data_q  <= 8'h00;
    end
    else
    begin
      ans_valid_q <= state_q == bcr_pkg::BCR_ST_ACCESS;
      if (state_q == bcr_pkg::BCR_ST_ACCESS)
      begin
        unique case (kind_q)
          bcr_pkg::BCR_KIND_NONE:   ans_data_q <= 8'h00;
          bcr_pkg::BCR_KIND_COMMON: ans_data_q <= write_q ? 8'h00 : common_rdata;
          bcr_pkg::BCR_KIND_CORE:   ans_data_q <= write_q ? 8'h00 : core_rdata;
          bcr_pkg::BCR_KIND_BUFFER: ans_data_q <= write_q ? 8'h00 : buf_rdata;
        endcase
      end
    end
  end

  bcr_common_regs u_common (
    .clk        (clk),
    .resetn     (resetn),
    .wr_en      (common_wr),
    .idx        (cidx_q),
    .wdata      (core_wdata_q),
    .rdata      (common_rdata),
    .flag_set   (flag_set),
    .status_in  (status_in),
    .int_en_q   (int_en_q),
    .int_flag_q (int_flag_q),
    .ctl_two_q  (ctl_two_q),
    .ctl_one_q  (ctl_one_q)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence seq_take;
    cmd_valid && cmd_ready_q;
  endsequence

  sequence seq_take_reg;
    cmd_valid && cmd_ready_q && !cmd_buffer;
  endsequence

  chk_answer_two_cycles: assert property (seq_take |=> !cmd_ready_q && !ans_valid_q
    ##1 ans_valid_q && cmd_ready_q)
    else $error("answer not two cycles after request");

  chk_unimpl_reads_zero: assert property (seq_take_reg ##0 (!cmd_write && cmd_addr < `BCR_COMMON_BASE
    && !is_impl(bank, cmd_addr)) |-> ##2 ans_data_q == 8'h00)
    else $error("unimplemented read not zero");

  chk_unimpl_no_strobe: assert property (seq_take_reg ##0 (cmd_addr < `BCR_COMMON_BASE
    && !is_impl(bank, cmd_addr)) |-> ##1 !core_rd_q && !core_wr_q)
    else $error("unimplemented access reached core");

  chk_common_no_bank: assert property (seq_take_reg ##0 (cmd_addr >= `BCR_COMMON_BASE)
    |-> ##1 !core_rd_q && !core_wr_q && !buf_rd_q && !buf_wr_q)
    else $error("common address left the block");

  chk_common_write_lands: assert property (seq_take_reg ##0 (cmd_write && cmd_addr == 5'h1f)
    |-> ##2 ctl_one_q == $past(cmd_wdata, 2))
    else $error("control one write lost");

  chk_bank_follows_sel: assert property ((take && core_wr_q == 1'b0) ##1 core_rd_q
    |-> core_bank_q == $past(ctl_one_q[1:0]))
    else $error("core bank differs from bank select");

  chk_reserved_blocked: assert property (seq_take_reg ##0 (cmd_addr == `BCR_RESERVED_1A)
    |-> ##1 !core_rd_q && !core_wr_q)
    else $error("reserved address reached core");

  chk_buffer_only_cmd: assert property ((buf_rd_q || buf_wr_q) |->
    $past(cmd_buffer) && !core_rd_q && !core_wr_q)
    else $error("buffer strobe without buffer command");

  chk_core_addr_range: assert property ((core_rd_q || core_wr_q) |-> core_addr_q < `BCR_RESERVED_1A)
    else $error("core strobe outside banked range");

endmodule // bcr_decode

/* File: rtl/bcr_map.svh */
`ifndef BCR_MAP_SVH
`define BCR_MAP_SVH

// First address of the common region and the reserved location
`define BCR_COMMON_BASE  5'h1b
`define BCR_RESERVED_1A  5'h1a

// Common register indices, address minus common base
`define BCR_IDX_INT_EN   3'h0
`define BCR_IDX_INT_FLAG 3'h1
`define BCR_IDX_STATUS   3'h2
`define BCR_IDX_CTL_TWO  3'h3
`define BCR_IDX_CTL_ONE  3'h4

// Implemented locations below the common region, one bit per address
`define BCR_IMPL_BANK0   32'h00ffffff
`define BCR_IMPL_BANK1   32'h03f3ffff
`define BCR_IMPL_BANK2   32'h03f77fdf
`define BCR_IMPL_BANK3   32'h03e407ff

// Reset values
`define BCR_RST_INT_EN   8'h00
`define BCR_RST_INT_FLAG 8'h00
`define BCR_RST_CTL_TWO  8'h80
`define BCR_RST_CTL_ONE  8'h00

// Writable and readable bit masks
`define BCR_WMASK_CTL_TWO  8'he8
`define BCR_RMASK_INT_FLAG 8'h7f
`define BCR_RMASK_STATUS   8'hf7

// Bank select field position in the first main control register
`define BCR_BANK_LSB     0
`define BCR_BANK_MSB     1

`endif

/* File: rtl/bcr_pkg.sv */
package bcr_pkg;

  typedef enum logic [1:0] {
    BCR_KIND_NONE,
    BCR_KIND_COMMON,
    BCR_KIND_CORE,
    BCR_KIND_BUFFER
  } bcr_kind_type;

  typedef enum logic {
    BCR_ST_IDLE,
    BCR_ST_ACCESS
  } bcr_state_type;

endpackage

/* File: sim/bcr_host_model.sv */
module bcr_host_model (
  // Clock
  input  wire logic       clk,
  // Command toward the decoder
  output logic            cmd_valid,
  output logic            cmd_write,
  output logic            cmd_buffer,
  output logic      [4:0] cmd_addr,
  output logic      [7:0] cmd_wdata,
  // Answer from the decoder
  input  wire logic       cmd_ready_q,
  input  wire logic       ans_valid_q,
  input  wire logic [7:0] ans_data_q
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    cmd_valid  = 1'b0;
    cmd_write  = 1'b0;
    cmd_buffer = 1'b0;
    cmd_addr   = 5'h00;
    cmd_wdata  = 8'h00;
  end

  task automatic xfer(input logic wr, input logic bf, input logic [4:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output logic ok);
    int n;
    ok = 1'b0;
    rd = 8'h00;
    if (!bf && a == 5'h1a)
      return;
    n = 0;
    while (cmd_ready_q !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (cmd_ready_q !== 1'b1)
      return;
    cmd_valid  = 1'b1;
    cmd_write  = wr;
    cmd_buffer = bf;
    cmd_addr   = a;
    cmd_wdata  = wd;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_addr  = ~a;
    cmd_wdata = ~wd;
    n = 0;
    while (ans_valid_q !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    if (ans_valid_q === 1'b1)
    begin
      rd = ans_data_q;
      ok = 1'b1;
    end
  endtask
endmodule // bcr_host_model

/* File: sim/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clk, resetn, cmd_valid, cmd_write, cmd_buffer, cmd_ready_q, ans_valid_q;
  logic       core_rd_q, core_wr_q, buf_rd_q, buf_wr_q;
  logic [1:0] core_bank_q;
  logic [4:0] cmd_addr, core_addr_q;
  logic [6:0] flag_set;
  logic [7:0] cmd_wdata, ans_data_q, core_wdata_q, core_rdata, buf_wdata_q, buf_rdata, status_in;
  logic [7:0] int_en_q, int_flag_q, ctl_two_q, ctl_one_q;
  int         fail_count, tests_run, core_hits, buf_hits;

  // Core and buffer answer only in their strobe cycle
  assign core_rdata = (core_rd_q === 1'b1) ? {core_bank_q, core_addr_q, 1'b1} : ~{core_bank_q, core_addr_q, 1'b1};
  assign buf_rdata  = (buf_rd_q === 1'b1) ? 8'h5a : 8'ha5;

  bcr_decode i_bcr_decode (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_buffer(cmd_buffer), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready_q(cmd_ready_q),
    .ans_valid_q(ans_valid_q), .ans_data_q(ans_data_q), .core_rd_q(core_rd_q), .core_wr_q(core_wr_q),
    .core_bank_q(core_bank_q), .core_addr_q(core_addr_q), .core_wdata_q(core_wdata_q),
    .core_rdata(core_rdata), .buf_rd_q(buf_rd_q), .buf_wr_q(buf_wr_q), .buf_wdata_q(buf_wdata_q),
    .buf_rdata(buf_rdata), .flag_set(flag_set), .status_in(status_in), .int_en_q(int_en_q),
    .int_flag_q(int_flag_q), .ctl_two_q(ctl_two_q), .ctl_one_q(ctl_one_q));

  bcr_host_model i_bcr_host_model (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_buffer(cmd_buffer), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_ready_q(cmd_ready_q),
    .ans_valid_q(ans_valid_q), .ans_data_q(ans_data_q));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(negedge clk)
  begin
    if (core_rd_q === 1'b1 || core_wr_q === 1'b1)
      core_hits++;
    if (buf_rd_q === 1'b1 || buf_wr_q === 1'b1)
      buf_hits++;
  end

  task automatic print_verdict();
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask

  task automatic acc(input logic wr, input logic bf, input logic [4:0] a, input logic [7:0] wd,
                     input logic [7:0] exp, input string what);
    logic [7:0] rd;
    logic       ok;
    i_bcr_host_model.xfer(wr, bf, a, wd, rd, ok);
    if (ok !== 1'b1)
    begin
      check({what, " answered"}, {7'h00, ok}, 8'h01);
      print_verdict();
    end
    check(what, rd, exp);
  endtask

  task automatic sc_reset();
    check("ctl_one_q", ctl_one_q, 8'h00);
    check("ctl_two_q", ctl_two_q, 8'h80);
    acc(1'b0, 1'b0, 5'h1f, 8'h00, 8'h00, "read ctl one");
    acc(1'b0, 1'b0, 5'h1e, 8'h00, 8'h80, "read ctl two");
    acc(1'b0, 1'b0, 5'h1c, 8'h00, 8'h00, "read flags");
  endtask

  task automatic sc_banks();
    logic [1:0] b;
    logic [7:0] prev;
    prev = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      b = 2'(i);
      acc(1'b1, 1'b0, 5'h1f, {6'h00, b}, 8'h00, "write bank");
      acc(1'b0, 1'b0, 5'h1f, 8'h00, {6'h00, b}, "read ctl one");
      acc(1'b0, 1'b0, 5'h1b, 8'h00, prev, "mirror int en");
      prev = 8'h10 + 8'(i);
      acc(1'b1, 1'b0, 5'h1b, prev, 8'h00, "write int en");
      acc(1'b0, 1'b0, 5'h1d, 8'h00, 8'hf7, "read status");
      acc(1'b0, 1'b0, 5'h00, 8'h00, {b, 5'h00, 1'b1}, "core read 00");
      acc(1'b0, 1'b0, 5'h19, 8'h00, (i == 0) ? 8'h00 : {b, 5'h19, 1'b1}, "read 19");
    end
  endtask

  task automatic sc_unimpl();
    int h;
    h = core_hits;
    acc(1'b1, 1'b0, 5'h0c, 8'h55, 8'h00, "write unimpl 0c");
    acc(1'b0, 1'b0, 5'h0c, 8'h00, 8'h00, "read unimpl 0c");
    acc(1'b0, 1'b0, 5'h13, 8'h00, 8'h00, "read unimpl 13");
    check("core strobes", 8'(core_hits - h), 8'h00);
    h = core_hits;
    acc(1'b1, 1'b0, 5'h05, 8'h77, 8'h00, "core write 05");
    check("core_wdata_q", core_wdata_q, 8'h77);
    check("core_addr_q", {3'h0, core_addr_q}, 8'h05);
    check("core_bank_q", {6'h00, core_bank_q}, 8'h03);
    check("core write strobes", 8'(core_hits - h), 8'h01);
    check("int_en_q", int_en_q, 8'h13);
  endtask

  task automatic sc_buffer();
    int h;
    int g;
    h = core_hits;
    g = buf_hits;
    acc(1'b1, 1'b1, 5'h1f, 8'h3c, 8'h00, "buffer write");
    check("buf_wdata_q", buf_wdata_q, 8'h3c);
    acc(1'b0, 1'b1, 5'h1f, 8'h00, 8'h5a, "buffer read");
    check("buffer strobes", 8'(buf_hits - g), 8'h02);
    check("core strobes", 8'(core_hits - h), 8'h00);
    check("ctl_one_q kept", ctl_one_q, 8'h03);
    acc(1'b1, 1'b1, 5'h00, 8'hc3, 8'h00, "buffer write two");
    check("buf_wdata_q two", buf_wdata_q, 8'hc3);
  endtask

  task automatic sc_flags();
    acc(1'b1, 1'b0, 5'h1c, 8'hff, 8'h00, "write flags");
    acc(1'b0, 1'b0, 5'h1c, 8'h00, 8'h7f, "read flags");
    acc(1'b1, 1'b0, 5'h1c, 8'h00, 8'h00, "clear flags");
    flag_set = 7'h04;
    @(negedge clk);
    flag_set = 7'h00;
    acc(1'b0, 1'b0, 5'h1c, 8'h00, 8'h04, "flag set");
    check("int_flag_q", int_flag_q, 8'h04);
    acc(1'b1, 1'b0, 5'h1e, 8'hff, 8'h00, "write ctl two");
    acc(1'b0, 1'b0, 5'h1e, 8'h00, 8'he8, "read ctl two mask");
    check("ctl_two_q mask", ctl_two_q, 8'he8);
  endtask

  initial
  begin
    fail_count = 0;
    tests_run  = 0;
    core_hits  = 0;
    buf_hits   = 0;
    resetn     = 1'b0;
    flag_set   = 7'h00;
    status_in  = 8'hff;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    sc_reset();
    sc_banks();
    sc_unimpl();
    sc_buffer();
    sc_flags();
    print_verdict();
  end
endmodule // tb
